// ---- verilog/relay_card_backplane_serial.sv ----
/*
 * Backplane serial engine: relay shift/strobe, card read, ID read,
 * power-on safeguard. Assumes one 250 MHz clock and card-side pins
 * outside the clock domain (synchronised here).
 */
// Operation
// - Route shared serial lines to selected slot
// - Shift five loaded bytes over forty clocks
// - Pulse strobe after forty bits shifted
// - First write drives output enable low
// - Read starts with strobe pulse
// - Assert read and select, forty clocks in
// - Hold enable low from first read strobe
// - Twelve sink lines plus eight serial
// - Relay, ID, I/O buses; forty lines
// - Read ID data at power-up
// - Start: data low while clock high
// - Send address, card acknowledges, returns data
// - Acknowledge bytes; card returns sequential data
// - Stop: data rises while clock high
// - Reset sets safeguard, drivers disabled
// - Safeguard stays high after reset release
// - First valid strobe clears safeguard
// - Safeguard stays low until reset
`timescale 1ns/100ps
`include "relay_card_defines.svh"
module relay_card_backplane_serial (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wr_req,
    input wire logic rd_req,
    input wire logic req_slot,
    input wire logic [39:0] wr_data,
    input wire logic [11:0] sink_in,
    input wire logic id_serial_data_in,
    input wire logic io_data_in,
    output logic busy,
    output logic [39:0] rd_data,
    output logic rd_valid,
    output logic [7:0] id_byte,
    output logic id_valid,
    output logic id_done,
    output logic slot_select,
    output logic slot_select_n,
    output logic [1:0] relay_clock,
    output logic [1:0] relay_data,
    output logic [1:0] strobe,
    output logic [1:0] id_serial_clock,
    output logic [1:0] id_serial_data_out,
    output logic [1:0] id_serial_data_oe,
    output logic [1:0] card_select,
    output logic read_write_n,
    output logic enable_n,
    output logic safeguard_q,
    output logic [11:0] sink_drive_n
);
    localparam int HALF = `HALF_CYC; // Cycles per serial half period
    localparam int IDB = `ID_BYTES * 9 + 9; // Address byte plus reads
    relay_card_pkg::seq_state_e st_q; // Sequencer state
    logic [15:0] tick_q; // Half-period timer
    logic [6:0] bit_q; // Bit counter
    logic [39:0] sh_q; // Shift register
    logic rd_mode_q; // Transfer is a card read
    logic [8:0] id_sh_q; // ID byte plus ack slot
    logic [3:0] id_cnt_q; // ID bytes taken
    logic [1:0] id_sync_q; // ID data synchroniser
    logic [1:0] io_sync_q; // I/O data synchroniser
    logic sdo_q; // Serial data level
    logic sck_q; // Serial clock level
    logic stb_q; // Strobe level
    logic idd_q; // ID data drive low when 0
    logic idc_q; // ID clock level
    logic cs_q; // Read select level
    logic half; // Half period elapsed

    // Slot steering of one level onto the pair of slot pins
    function automatic logic [1:0] steer(input logic s, input logic v);
        steer = s ? {v, 1'b0} : {1'b0, v};
    endfunction
    assign half = (tick_q == 16'(HALF - 1));
    // Synchronise card returns before use
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            id_sync_q <= 2'h3;
            io_sync_q <= 2'h0;
        end else begin
            id_sync_q <= {id_sync_q[0], id_serial_data_in};
            io_sync_q <= {io_sync_q[0], io_data_in};
        end
    end
    // Half-period timer, runs while not idle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= 16'h0;
        end else if (st_q == relay_card_pkg::ST_IDLE || half) begin
            tick_q <= 16'h0;
        end else begin
            tick_q <= tick_q + 16'h1;
        end
    end
    // Slot latched at request in idle, steady until the next request
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_select <= 1'b0;
            slot_select_n <= 1'b1;
        end else if (st_q == relay_card_pkg::ST_IDLE && (wr_req || rd_req)) begin
            slot_select <= req_slot;
            slot_select_n <= ~req_slot;
        end
    end
    // Main sequencer: relay write, card read, ID read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= relay_card_pkg::ST_ID_START;
            bit_q <= 7'h0;
            sh_q <= 40'h0;
            rd_mode_q <= 1'b0;
            sdo_q <= 1'b0;
            sck_q <= 1'b0;
            stb_q <= 1'b0;
            cs_q <= 1'b0;
            idd_q <= 1'b1;
            idc_q <= 1'b1;
            id_sh_q <= 9'h0;
            id_cnt_q <= 4'h0;
        end else begin
            unique case (st_q)
                relay_card_pkg::ST_IDLE: begin
                    bit_q <= 7'h0;
                    if (wr_req) begin
                        sh_q <= wr_data;
                        rd_mode_q <= 1'b0;
                        st_q <= relay_card_pkg::ST_LOW;
                    end else if (rd_req) begin
                        rd_mode_q <= 1'b1;
                        st_q <= relay_card_pkg::ST_STROBE;
                    end
                end
                relay_card_pkg::ST_LOW: begin
                    sck_q <= 1'b0;
                    sdo_q <= sh_q[39];
                    if (half) begin
                        st_q <= relay_card_pkg::ST_HIGH;
                    end
                end
                relay_card_pkg::ST_HIGH: begin
                    sck_q <= 1'b1;
                    if (half) begin
                        sh_q <= {sh_q[38:0], io_sync_q[1]};
                        bit_q <= bit_q + 7'h1;
                        if (bit_q == 7'(`FRAME_BITS - 1)) begin
                            sck_q <= 1'b0;
                            cs_q <= 1'b0;
                            st_q <= rd_mode_q ? relay_card_pkg::ST_IDLE
                                : relay_card_pkg::ST_STROBE;
                        end else begin
                            st_q <= relay_card_pkg::ST_LOW;
                        end
                    end
                end
                relay_card_pkg::ST_STROBE: begin
                    stb_q <= 1'b1;
                    if (half) begin
                        st_q <= relay_card_pkg::ST_STRB_LO;
                    end
                end
                relay_card_pkg::ST_STRB_LO: begin
                    stb_q <= 1'b0;
                    if (half) begin
                        cs_q <= rd_mode_q;
                        st_q <= rd_mode_q ? relay_card_pkg::ST_LOW
                            : relay_card_pkg::ST_IDLE;
                    end
                end
                relay_card_pkg::ST_ID_START: begin
                    idd_q <= 1'b0;
                    idc_q <= 1'b1;
                    id_sh_q <= {`ID_ADDR, 1'b1};
                    if (half) begin
                        st_q <= relay_card_pkg::ST_ID_LOW;
                    end
                end
                relay_card_pkg::ST_ID_LOW: begin
                    idc_q <= 1'b0;
                    // Address, then acks; data moves after clock falls
                    if (tick_q != 16'h0 && bit_q < 7'h9) begin
                        idd_q <= id_sh_q[8];
                    end else if (tick_q != 16'h0) begin
                        idd_q <= (bit_q % 7'h9 == 7'h8 &&
                            id_cnt_q != 4'(`ID_BYTES - 1)) ? 1'b0 : 1'b1;
                    end
                    if (half) begin
                        st_q <= relay_card_pkg::ST_ID_HIGH;
                    end
                end
                relay_card_pkg::ST_ID_HIGH: begin
                    idc_q <= 1'b1;
                    if (half) begin
                        id_sh_q <= {id_sh_q[7:0], id_sync_q[1]};
                        bit_q <= bit_q + 7'h1;
                        if (bit_q >= 7'h9 && bit_q % 7'h9 == 7'h8) begin
                            id_cnt_q <= id_cnt_q + 4'h1;
                        end
                        if (bit_q == 7'(IDB - 1)) begin
                            st_q <= relay_card_pkg::ST_ID_STOP;
                        end else begin
                            st_q <= relay_card_pkg::ST_ID_LOW;
                        end
                    end
                end
                relay_card_pkg::ST_ID_STOP: begin
                    idc_q <= 1'b0;
                    if (half) begin
                        idd_q <= 1'b0; // Low before the clock rises
                        st_q <= relay_card_pkg::ST_ID_DONE;
                    end
                end
                relay_card_pkg::ST_ID_DONE: begin
                    idc_q <= 1'b1;
                    if (half) begin
                        idd_q <= 1'b1;
                        bit_q <= 7'h0;
                        st_q <= relay_card_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_q <= relay_card_pkg::ST_IDLE;
                end
            endcase
        end
    end
    // Registered pin drive; relay, strobe and select lines steered to the chosen slot
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            relay_clock <= 2'h0;
            relay_data <= 2'h0;
            strobe <= 2'h0;
            card_select <= 2'h0;
            read_write_n <= 1'b1;
            id_serial_clock <= 2'h3;
            id_serial_data_out <= 2'h0;
            id_serial_data_oe <= 2'h0;
            busy <= 1'b1;
        end else begin
            relay_clock <= steer(slot_select, sck_q);
            relay_data <= steer(slot_select, sdo_q);
            strobe <= steer(slot_select, stb_q);
            card_select <= steer(slot_select, cs_q);
            read_write_n <= ~cs_q;
            // Both slots read ID together; open drain pulls low
            id_serial_clock <= {idc_q, idc_q};
            id_serial_data_out <= 2'h0;
            id_serial_data_oe <= {~idd_q, ~idd_q};
            busy <= st_q != relay_card_pkg::ST_IDLE;
        end
    end
    // Captured results for the processor side
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 40'h0;
            rd_valid <= 1'b0;
            id_byte <= 8'h0;
            id_valid <= 1'b0;
            id_done <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            id_valid <= 1'b0;
            if (st_q == relay_card_pkg::ST_HIGH && half && rd_mode_q &&
                bit_q == 7'(`FRAME_BITS - 1)) begin
                rd_data <= {sh_q[38:0], io_sync_q[1]};
                rd_valid <= 1'b1;
            end
            if (st_q == relay_card_pkg::ST_ID_HIGH && half && bit_q > 7'h9 &&
                bit_q % 7'h9 == 7'h7) begin
                id_byte <= {id_sh_q[6:0], id_sync_q[1]};
                id_valid <= 1'b1;
            end
            if (st_q == relay_card_pkg::ST_ID_DONE && half) begin
                id_done <= 1'b1;
            end
        end
    end
    // Safeguard set by reset, cleared by first strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            safeguard_q <= 1'b1;
            enable_n <= 1'b1;
        end else if (st_q == relay_card_pkg::ST_STRB_LO && half) begin
            safeguard_q <= 1'b0;
            enable_n <= 1'b0;
        end
    end
    // Direct sink lines, low energizes, gated by safeguard
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sink_drive_n <= 12'hfff;
        end else begin
            sink_drive_n <= safeguard_q ? 12'hfff : ~sink_in;
        end
    end
    // Strobe is a high-then-low pulse after the fortieth bit
    sequence strobe_pulse_s;
        stb_q ##1 stb_q ##[1:40] !stb_q;
    endsequence
    strobe_after_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n) st_q == relay_card_pkg::ST_HIGH && half &&
        !rd_mode_q && bit_q == 7'd39 |-> ##2 strobe_pulse_s)
        else $error("strobe did not follow the frame");
    guard_stays_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n) !safeguard_q |=> !safeguard_q)
        else $error("safeguard rose without reset");
    guard_clear_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        $fell(safeguard_q) |-> $past(st_q) == relay_card_pkg::ST_STRB_LO)
        else $error("safeguard cleared without strobe");
    slot_hold_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        st_q != relay_card_pkg::ST_IDLE |=> $stable(slot_select))
        else $error("slot changed during transfer");
    slot_pair_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n) slot_select_n == ~slot_select)
        else $error("slot select pair not complementary");
    bit_count_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        st_q == relay_card_pkg::ST_LOW |-> bit_q < 7'd40)
        else $error("frame exceeded forty bits");
    enable_follow_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        st_q == relay_card_pkg::ST_STRB_LO && half |=> !enable_n)
        else $error("enable not low after strobe");
    id_start_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        $fell(idd_q) && st_q == relay_card_pkg::ST_ID_START |-> idc_q)
        else $error("start without clock high");
endmodule

// ---- common/relay_card_defines.svh ----
/*
 * Timing and size constants for the relay card backplane serial block.
 * Assumes a 250 MHz system clock; included by its bare name.
 */
`ifndef RELAY_CARD_DEFINES_SVH
`define RELAY_CARD_DEFINES_SVH
// System clock period in ps
`define CLK_PERIOD_PS 4000
// Relay frame length in bits and bytes
`define FRAME_BITS 40
`define FRAME_BYTES 5
// Serial half period in ns and in cycles
`define HALF_NS 40
`define HALF_CYC ((`HALF_NS * 1000) / `CLK_PERIOD_PS)
// Safeguard delay in ms; unused, the first strobe clears the safeguard
`define GUARD_MS 200
`define GUARD_CYC (`GUARD_MS * (1000000000 / `CLK_PERIOD_PS))
// ID bytes per power-up read and ID start address
`define ID_BYTES 8
`define ID_ADDR 8'h00
`endif

// ---- common/relay_card_pkg.sv ----
/*
 * Types for the relay card backplane serial block.
 * Assumes nothing beyond the defines header.
 */
package relay_card_pkg;
    // Sequencer states, Gray-coded along the shift path
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_LOW = 4'h1,
        ST_HIGH = 4'h3,
        ST_STROBE = 4'h2,
        ST_STRB_LO = 4'h6,
        ST_ID_START = 4'h7,
        ST_ID_LOW = 4'h5,
        ST_ID_HIGH = 4'h4,
        ST_ID_STOP = 4'hc,
        ST_ID_DONE = 4'hd
    } seq_state_e;
endpackage

// ---- tb/card_side_model.sv ----
/*
 * Behavioural model of a plug-in card: relay driver chain, I/O
 * register and ID memory on a pulled-up open-drain data wire.
 * Assumes the block's card-side outputs as inputs here.
 */
`timescale 1ns/100ps
module card_side_model (
    input wire logic [1:0] relay_clock,
    input wire logic [1:0] relay_data,
    input wire logic [1:0] strobe,
    input wire logic [1:0] card_select,
    input wire logic read_write_n,
    input wire logic [1:0] id_serial_clock,
    input wire logic [1:0] id_serial_data_oe,
    input wire logic [39:0] io_pattern,
    output logic io_data_in,
    output logic id_serial_data_in,
    output logic [1:0][39:0] latched,
    output int clk_cnt [2],
    output int rd_cnt [2],
    output logic [7:0] id_addr,
    output int start_cnt,
    output int stop_cnt
);
    logic [7:0] rom [16]; // Card ID contents
    logic [39:0] chain [2]; // Driver shift chain per slot
    logic [39:0] io_sr [2]; // Parallel-to-serial input register
    int run_cnt [2]; // Write-clock rises since last strobe
    logic sda_low = 1'h0; // Card pulls data low
    logic sending = 1'h1; // Card still wants to send
    logic in_frame = 1'h0; // Between start and stop
    int bit_n = 0; // Clock rises since start
    int j;
    wire scl = id_serial_clock[0];
    // Open-drain wire with pull-up: low if anyone pulls
    wire sda = ~(|id_serial_data_oe) & ~sda_low;
    assign id_serial_data_in = sda;
    // Unselected card leaves the line showing the inverse
    assign io_data_in = card_select[1] ? io_sr[1][39] :
        card_select[0] ? io_sr[0][39] : ~io_sr[0][39];
    initial begin
        start_cnt = 0;
        stop_cnt = 0;
        latched = '0;
        for (int i = 0; i < 16; i++) begin
            rom[i] = 8'h5a ^ 8'(i * 19);
        end
    end
    // Start: data falls with clock high
    always @(negedge sda) if (scl) begin
        start_cnt++;
        in_frame = 1'h1;
        sending = 1'h1;
        bit_n = 0;
    end
    // Stop: data rises with clock high
    always @(posedge sda) if (scl && in_frame) begin
        stop_cnt++;
        in_frame = 1'h0;
    end
    // Address in MSB first; master ack slot ends sending on high
    always @(posedge scl) if (in_frame) begin
        if (bit_n < 8) id_addr = {id_addr[6:0], sda};
        if (bit_n >= 9 && (bit_n - 9) % 9 == 8 && sda) sending = 1'h0;
        bit_n++;
    end
    // Ack the address, then sequential bytes MSB first
    always @(negedge scl) begin
        j = bit_n - 9;
        sda_low = 1'h0;
        if (in_frame && bit_n == 8) sda_low = 1'h1;
        else if (in_frame && sending && j >= 0 && j % 9 < 8)
            sda_low = ~rom[(id_addr + j / 9) & 15][7 - j % 9];
    end
    for (genvar s = 0; s < 2; s++) begin : g_slot
        // Chain shifts on the relay clock; strobe latches it
        always @(posedge relay_clock[s]) begin
            chain[s] = {chain[s][38:0], relay_data[s]};
            if (!card_select[s]) run_cnt[s]++;
            if (card_select[s] && !read_write_n) rd_cnt[s]++;
        end
        // Strobe latches drivers and captures card inputs
        always @(posedge strobe[s]) begin
            latched[s] = chain[s];
            clk_cnt[s] = run_cnt[s];
            run_cnt[s] = 0;
            rd_cnt[s] = 0;
            io_sr[s] = io_pattern;
        end
        // Next I/O bit after each clock while selected
        always @(negedge relay_clock[s]) if (card_select[s])
            io_sr[s] = {io_sr[s][38:0], ~io_sr[s][39]};
    end
endmodule

// ---- tb/relay_card_backplane_serial_tb.sv ----
/*
 * Self-checking bench for the relay card backplane serial block.
 * Assumes the card-side model and a 250 MHz clock.
 */
`timescale 1ns/100ps
`include "relay_card_defines.svh"
module relay_card_backplane_serial_tb;
    typedef struct packed {
        logic rd;
        logic slot;
        logic [39:0] val;
    } row_s;
    logic sys_clk, rst_n, wr_req, rd_req, req_slot, io_data_in;
    logic [39:0] wr_data, io_pattern, rd_data, rd_seen;
    logic [11:0] sink_in, sink_drive_n;
    logic id_serial_data_in, busy, rd_valid, id_valid, id_done, sel;
    logic slot_select, slot_select_n, read_write_n, enable_n;
    logic safeguard_q;
    logic [7:0] id_byte, id_addr;
    logic [1:0] relay_clock, relay_data, strobe, id_serial_clock;
    logic [1:0] id_serial_data_out, id_serial_data_oe, card_select;
    logic [1:0][39:0] latched, exp_lat;
    int clk_cnt [2], rd_cnt [2];
    int start_cnt, stop_cnt, rd_pulses = 0, pulses;
    int miscompares = 0, tests_run = 0;
    logic [7:0] id_q [$];
    // Ordinary transfers: boundary and mixed patterns on both slots
    row_s rows [5] = '{'{1'h0, 1'h0, 40'hff_ffff_ffff},
        '{1'h0, 1'h1, 40'h00_0000_0001}, '{1'h1, 1'h0, 40'ha5_c33c_0f96},
        '{1'h0, 1'h0, 40'h80_0000_0000}, '{1'h1, 1'h1, 40'h12_3456_789a}};
    relay_card_backplane_serial dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .wr_req(wr_req), .rd_req(rd_req), .req_slot(req_slot),
        .wr_data(wr_data), .sink_in(sink_in),
        .id_serial_data_in(id_serial_data_in), .io_data_in(io_data_in),
        .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid),
        .id_byte(id_byte), .id_valid(id_valid), .id_done(id_done),
        .slot_select(slot_select), .slot_select_n(slot_select_n),
        .relay_clock(relay_clock), .relay_data(relay_data),
        .strobe(strobe), .id_serial_clock(id_serial_clock),
        .id_serial_data_out(id_serial_data_out),
        .id_serial_data_oe(id_serial_data_oe), .card_select(card_select),
        .read_write_n(read_write_n), .enable_n(enable_n),
        .safeguard_q(safeguard_q), .sink_drive_n(sink_drive_n));
    card_side_model card (.relay_clock(relay_clock),
        .relay_data(relay_data), .strobe(strobe),
        .card_select(card_select), .read_write_n(read_write_n),
        .id_serial_clock(id_serial_clock),
        .id_serial_data_oe(id_serial_data_oe), .io_pattern(io_pattern),
        .io_data_in(io_data_in), .id_serial_data_in(id_serial_data_in),
        .latched(latched), .clk_cnt(clk_cnt), .rd_cnt(rd_cnt),
        .id_addr(id_addr), .start_cnt(start_cnt), .stop_cnt(stop_cnt));
    // Clock generator
    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Collect one-cycle result pulses where settled
    always @(negedge sys_clk) begin
        if (rd_valid === 1'h1) begin
            rd_seen = rd_data;
            rd_pulses++;
        end
        if (id_valid === 1'h1) id_q.push_back(id_byte);
    end
    // Compare and count
    task automatic check(input logic [39:0] seen, input logic [39:0] exp,
            input string what);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s: %h vs %h", $time, what, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Wait for busy to fall, bounded
    task automatic wait_idle;
        int n;
        n = 0;
        @(negedge sys_clk);
        while (busy !== 1'h0 && n < 5000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 5000) check(40'h1, 40'h0, "busy stuck");
    endtask
    // Issue one request and wait for completion
    task automatic xfer(input row_s r);
        @(negedge sys_clk);
        req_slot = r.slot;
        wr_data = r.val;
        io_pattern = r.val;
        wr_req = ~r.rd;
        rd_req = r.rd;
        @(negedge sys_clk);
        wr_req = 1'h0;
        rd_req = 1'h0;
        wait_idle();
    endtask
    // Watchdog
    initial begin
        #100000;
        miscompares++;
        finish_test();
    end
    initial begin
        rst_n = 1'h0;
        {wr_req, rd_req, req_slot} = 3'h0;
        wr_data = 40'h0;
        io_pattern = 40'h0;
        sink_in = 12'ha5c;
        exp_lat = 80'h0;
        repeat (6) @(negedge sys_clk);
        check(40'(safeguard_q), 40'h1, "guard in reset");
        check(40'(sink_drive_n), 40'hfff, "sinks in reset");
        rst_n = 1'h1;
        wait_idle();
        check(40'(id_done), 40'h1, "id done");
        check(40'(start_cnt), 40'h1, "starts");
        check(40'(stop_cnt), 40'h1, "stops");
        check(40'(id_serial_data_out), 40'h0, "id drive");
        check(40'(id_addr), 40'(`ID_ADDR), "id address");
        check(40'(id_q.size()), 40'(`ID_BYTES), "id count");
        foreach (id_q[i])
            check(40'(id_q[i]), 40'(8'h5a ^ 8'((`ID_ADDR + i) * 19)),
                "id byte");
        check(40'(safeguard_q), 40'h1, "guard after reset");
        check(40'(enable_n), 40'h1, "enable before strobe");
        $display("test id read done");
        foreach (rows[i]) begin
            xfer(rows[i]);
            if (rows[i].rd) begin
                check(rd_seen, rows[i].val, "read data");
                check(40'(rd_cnt[rows[i].slot]), 40'd40, "rd clk");
            end else begin
                exp_lat[rows[i].slot] = rows[i].val;
                check(40'(clk_cnt[rows[i].slot]), 40'd40, "clks");
            end
            check(latched[0], exp_lat[0], "slot 1 latch");
            check(latched[1], exp_lat[1], "slot 2 latch");
            check(40'(slot_select ^ slot_select_n), 40'h1, "sel");
            check(40'(safeguard_q), 40'h0, "guard off");
            check(40'(enable_n), 40'h0, "enable");
            check(40'(sink_drive_n), {28'h0, ~sink_in}, "sinks");
            $display("test row %0d done", i);
        end
        // Request during a write is ignored; slot held
        xfer('{1'h0, 1'h0, 40'h0f_0f0f_0f0f});
        @(negedge sys_clk);
        wr_data = 40'h33_cc33_cc33;
        wr_req = 1'h1;
        @(negedge sys_clk);
        wr_req = 1'h0;
        repeat (200) @(negedge sys_clk);
        sel = slot_select;
        pulses = rd_pulses;
        req_slot = 1'h1;
        rd_req = 1'h1;
        repeat (200) @(negedge sys_clk);
        rd_req = 1'h0;
        check(40'(slot_select), 40'(sel), "slot moved");
        wait_idle();
        check(40'(rd_pulses), 40'(pulses), "busy refusal");
        check(latched[0], 40'h33_cc33_cc33, "second write");
        $display("test busy refusal done");
        // Reset in mid-write re-arms the safeguard
        @(negedge sys_clk);
        wr_req = 1'h1;
        @(negedge sys_clk);
        wr_req = 1'h0;
        repeat (100) @(negedge sys_clk);
        rst_n = 1'h0;
        repeat (6) @(negedge sys_clk);
        check(40'(safeguard_q), 40'h1, "guard re-armed");
        rst_n = 1'h1;
        wait_idle();
        check(40'(start_cnt), 40'h2, "second id read");
        check(40'(safeguard_q), 40'h1, "guard held");
        check(40'(sink_drive_n), 40'hfff, "sinks held");
        xfer('{1'h0, 1'h1, 40'h5a_a5f0_0f99});
        check(latched[1], 40'h5a_a5f0_0f99, "write after reset");
        check(40'(safeguard_q), 40'h0, "guard cleared");
        $display("test mid-run reset done");
        finish_test();
    end
endmodule
